/* File: common/event_router_pkg.sv */
// Constants, register map and carrier types of the event router
// Summary of operation
// - Four interrupt outputs toward the collector plus one wake output.
// - An output rises when a routed, unmasked input shows an event.
// - Each input routes to any mix of interrupt and wake outputs.
// - Inputs come from internal system signals and from every GPIO-capable pin.
// - Each input acts directly on its level or through an edge latch.
// - Active polarity is programmed separately for each input.
// - A direct event vanishes as soon as its input goes inactive.
// - A latched event stays until software clears it.
// - A global enable per input blocks it from every output.
// - A per-input, per-output enable blocks it from single outputs.
// - Software reads which events drive each output separately.
// - Direct event detection does not depend on a running clock; edge latching needs pclk.
// - The wake output can rise with all clocks stopped.
// - GPIO-capable pins trigger events in functional or GPIO mode.
package event_router_pkg;
   localparam int NUM_IRQ  = 4;
   localparam int NUM_OUT  = NUM_IRQ + 1;
   localparam int WAKE_IDX = NUM_IRQ;

   localparam logic [11:0] POL_OFS     = 12'h000;
   localparam logic [11:0] MODE_OFS    = 12'h004;
   localparam logic [11:0] GEN_EN_OFS  = 12'h008;
   localparam logic [11:0] LATCH_OFS   = 12'h00C;
   localparam logic [11:0] RAW_OFS     = 12'h010;
   localparam logic [11:0] OUT_EN_BASE = 12'h020;
   localparam logic [11:0] STAT_BASE   = 12'h040;
   localparam logic [11:0] OUT_STRIDE  = 12'h004;

   localparam logic [31:0] POL_RST    = 32'hFFFFFFFF;
   localparam logic [31:0] MODE_RST   = 32'h00000000;
   localparam logic [31:0] GEN_EN_RST = 32'h00000000;
   localparam logic [31:0] OUT_EN_RST = 32'h00000000;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;
endpackage : event_router_pkg

/* File: sim/event_router_partner.sv */
// Far-side model: clock generation unit counting wake requests
`timescale 1ns/1ps
module event_router_partner (
   input  wire logic       presetn,
   input  wire logic       wake,
   output logic [7:0]      restore_cnt_q
);
   // Edge of wake itself: no system clock runs in suspend
   always_ff @(posedge wake or negedge presetn) begin
      if (!presetn)
         restore_cnt_q <= 8'h00;
      else
         restore_cnt_q <= restore_cnt_q + 8'h01;
   end
endmodule : event_router_partner

/* File: sim/event_router_test.sv */
// Self-checking bench for the event router
`timescale 1ns/1ps
module event_router_test;
   event_router_pkg::apb_req_type req;
   event_router_pkg::apb_rsp_type rsp;
   logic        pclk, presetn, run, wake, err;
   logic [15:0] sys_evt, gpio_in;
   logic [3:0]  irq;
   logic [7:0]  restore_cnt_q, c0;
   logic [31:0] rdat;
   int          fails, n_checks;

   event_router dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .sys_evt(sys_evt), .gpio_in(gpio_in), .irq(irq), .wake(wake));
   event_router_partner clock_generation_unit (.presetn(presetn), .wake(wake),
      .restore_cnt_q(restore_cnt_q));

   // Gated so the suspend case can stop every clock
   always #10 if (run) pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %0t %s", $time, m);
         fails++;
      end
   endtask : chk

   // Called right after a rising edge; ends one idle edge later
   // Waits for pready as long as it takes; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h00000000);
      chk(rdat, e, m);
   endtask : rd

   task automatic out(input logic [31:0] e, input string m);
      @(posedge pclk);
      chk({27'h0, wake, irq}, e, m);
   endtask : out

   function automatic logic [11:0] adr(input logic [11:0] b, input int o);
      return b + 12'(4 * o);
   endfunction : adr

   task automatic t_reset;
      rd(event_router_pkg::POL_OFS, event_router_pkg::POL_RST, "pol reset");
      rd(event_router_pkg::MODE_OFS, event_router_pkg::MODE_RST, "mode reset");
      rd(event_router_pkg::GEN_EN_OFS, event_router_pkg::GEN_EN_RST, "gen reset");
      out(32'h0, "outputs at reset");
   endtask : t_reset

   task automatic t_route;
      wr(event_router_pkg::GEN_EN_OFS, 32'h0000001F);
      for (int o = 0; o < 5; o++) begin
         wr(adr(event_router_pkg::OUT_EN_BASE, o), 32'h1 << o);
      end
      for (int o = 0; o < 5; o++) begin
         sys_evt <= 16'h1 << o;
         out(32'h1 << o, "routed output");
         rd(adr(event_router_pkg::STAT_BASE, o), 32'h1 << o, "status");
      end
      sys_evt <= 16'h0000;
      out(32'h0, "direct drop");
   endtask : t_route

   task automatic t_mask;
      wr(event_router_pkg::OUT_EN_BASE, 32'h00000003);
      sys_evt <= 16'h0003;
      out(32'h3, "or of events");
      rd(event_router_pkg::RAW_OFS, 32'h00000003, "raw level");
      rd(event_router_pkg::OUT_EN_BASE, 32'h00000003, "enable readback");
      wr(adr(event_router_pkg::OUT_EN_BASE, 1), 32'h0);
      out(32'h1, "per output mask");
      wr(event_router_pkg::GEN_EN_OFS, 32'h0000001D);
      sys_evt <= 16'h0002;
      out(32'h0, "global mask");
      sys_evt <= 16'h0000;
   endtask : t_mask

   task automatic t_wake;
      gpio_in <= 16'h0001;
      wr(event_router_pkg::POL_OFS, 32'hFFFEFFFF);
      wr(event_router_pkg::GEN_EN_OFS, 32'h00010000);
      wr(adr(event_router_pkg::OUT_EN_BASE, 3), 32'h00010000);
      wr(adr(event_router_pkg::OUT_EN_BASE, 4), 32'h00010000);
      out(32'h0, "low active idle");
      c0 = restore_cnt_q;
      @(negedge pclk);
      run = 1'b0;
      gpio_in = 16'h0000;
      #100;
      chk({30'h0, wake, irq[3]}, 32'h3, "wake no clock");
      chk(32'(restore_cnt_q), 32'(c0 + 8'h01), "clocks restored");
      run = 1'b1;
      @(posedge pclk);
      gpio_in <= 16'h0001;
      out(32'h0, "wake drop");
   endtask : t_wake

   task automatic t_latch;
      wr(event_router_pkg::POL_OFS, 32'hFFFFFFFF);
      wr(event_router_pkg::MODE_OFS, 32'h00000004);
      wr(event_router_pkg::GEN_EN_OFS, 32'h00000004);
      wr(adr(event_router_pkg::OUT_EN_BASE, 2), 32'h00000004);
      sys_evt <= 16'h0004;
      @(posedge pclk);
      sys_evt <= 16'h0000;
      repeat (3) @(posedge pclk);
      out(32'h4, "latch holds");
      rd(event_router_pkg::LATCH_OFS, 32'h4, "latch read");
      wr(event_router_pkg::LATCH_OFS, 32'h4);
      out(32'h0, "latch cleared");
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
   endtask : t_latch

   task automatic tally_and_finish;
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      run = 1'b1;
      req = '0;
      sys_evt = '0;
      gpio_in = '0;
      fails = 0;
      n_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_route;
      t_mask;
      t_wake;
      t_latch;
      tally_and_finish;
   end

   initial begin
      #200000;
      fails++;
      tally_and_finish;
   end
endmodule : event_router_test

/* File: src/event_router.sv */
// Event router: level or edge events routed to interrupt and wake outputs
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module event_router #(
   parameter int NUM_SYS  = 16,
   parameter int NUM_GPIO = 16
) (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire event_router_pkg::apb_req_type     apb_req,
   output event_router_pkg::apb_rsp_type          apb_rsp,
   input  wire logic [NUM_SYS-1:0]                sys_evt,
   input  wire logic [NUM_GPIO-1:0]               gpio_in,
   output logic [event_router_pkg::NUM_IRQ-1:0]   irq,
   output logic                                   wake
);
   localparam int NI = NUM_SYS + NUM_GPIO;
   localparam int NO = event_router_pkg::NUM_OUT;

   typedef logic [NI-1:0] vec_type;

   // Zero-extend an input-wide vector onto the data bus
   function automatic logic [31:0] widen(input vec_type v);
      logic [31:0] r;
      r         = '0;
      r[NI-1:0] = v;
      return r;
   endfunction : widen

   // Output index behind a strided block, or NO when outside it
   function automatic int unsigned out_slot(input logic [11:0] a,
                                            input logic [11:0] base);
      int unsigned s;
      s = NO;
      for (int o = 0; o < NO; o++) begin
         if (a == base + 12'(o) * event_router_pkg::OUT_STRIDE) begin
            s = o;
         end
      end
      return s;
   endfunction : out_slot

   vec_type pol_q;
   vec_type mode_q;
   vec_type gen_en_q;
   vec_type lat_q;
   vec_type lat_d;
   vec_type act_q;
   vec_type out_en_q [NO];
   logic [31:0] prdata_q;

   vec_type pin_w;
   vec_type act_w;
   vec_type edge_w;
   vec_type clr_w;
   vec_type ev_w;
   vec_type route_w [NO];

   // Pads are sensed whatever the pin mux does with them
   assign pin_w  = {gpio_in, sys_evt};
   assign act_w  = ~(pin_w ^ pol_q);
   assign edge_w = act_w & ~act_q & mode_q;

   // Direct events are pure logic so wake works with pclk stopped
   assign ev_w = (mode_q & lat_q) | (~mode_q & act_w);

   genvar go;
   generate
      for (go = 0; go < NO; go++) begin : g_route
         assign route_w[go] = ev_w & gen_en_q & out_en_q[go];
      end
      for (go = 0; go < event_router_pkg::NUM_IRQ; go++) begin : g_irq
         assign irq[go] = |route_w[go];
      end
   endgenerate

   assign wake = |route_w[event_router_pkg::WAKE_IDX];

   // APB decode
   logic        setup_w;
   logic        access_w;
   logic        wr_w;
   logic [11:0] addr_w;
   int unsigned en_slot_w;
   int unsigned st_slot_w;
   logic        mapped_w;
   logic [31:0] rd_mux_w;

   assign addr_w    = apb_req.paddr;
   assign setup_w   = apb_req.psel & ~apb_req.penable;
   assign access_w  = apb_req.psel & apb_req.penable;
   assign wr_w      = access_w & apb_req.pwrite & mapped_w;
   assign en_slot_w = out_slot(addr_w, event_router_pkg::OUT_EN_BASE);
   assign st_slot_w = out_slot(addr_w, event_router_pkg::STAT_BASE);
   assign mapped_w  = addr_w == event_router_pkg::POL_OFS
                   || addr_w == event_router_pkg::MODE_OFS
                   || addr_w == event_router_pkg::GEN_EN_OFS
                   || addr_w == event_router_pkg::LATCH_OFS
                   || addr_w == event_router_pkg::RAW_OFS
                   || en_slot_w < NO
                   || st_slot_w < NO;

   always_comb begin
      rd_mux_w = '0;
      if (addr_w == event_router_pkg::POL_OFS) begin
         rd_mux_w = widen(pol_q);
      end else if (addr_w == event_router_pkg::MODE_OFS) begin
         rd_mux_w = widen(mode_q);
      end else if (addr_w == event_router_pkg::GEN_EN_OFS) begin
         rd_mux_w = widen(gen_en_q);
      end else if (addr_w == event_router_pkg::LATCH_OFS) begin
         rd_mux_w = widen(lat_q);
      end else if (addr_w == event_router_pkg::RAW_OFS) begin
         rd_mux_w = widen(act_w);
      end else if (en_slot_w < NO) begin
         rd_mux_w = widen(out_en_q[en_slot_w]);
      end else if (st_slot_w < NO) begin
         rd_mux_w = widen(route_w[st_slot_w]);
      end
   end

   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = access_w & ~mapped_w;
   assign apb_rsp.prdata  = prdata_q;

   // Write-one-to-clear; a fresh edge in the same cycle wins
   assign clr_w = (wr_w && addr_w == event_router_pkg::LATCH_OFS)
                ? apb_req.pwdata[NI-1:0] : '0;
   assign lat_d = (lat_q & ~clr_w) | edge_w;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q    <= '0;
         act_q    <= '0;
         prdata_q <= '0;
      end else begin
         lat_q <= lat_d;
         act_q <= act_w;
         if (setup_w && !apb_req.pwrite) begin
            prdata_q <= rd_mux_w;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_q    <= event_router_pkg::POL_RST[NI-1:0];
         mode_q   <= event_router_pkg::MODE_RST[NI-1:0];
         gen_en_q <= event_router_pkg::GEN_EN_RST[NI-1:0];
      end else if (wr_w) begin
         if (addr_w == event_router_pkg::POL_OFS) begin
            pol_q <= apb_req.pwdata[NI-1:0];
         end
         if (addr_w == event_router_pkg::MODE_OFS) begin
            mode_q <= apb_req.pwdata[NI-1:0];
         end
         if (addr_w == event_router_pkg::GEN_EN_OFS) begin
            gen_en_q <= apb_req.pwdata[NI-1:0];
         end
      end
   end

   generate
      for (go = 0; go < NO; go++) begin : g_en
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               out_en_q[go] <= event_router_pkg::OUT_EN_RST[NI-1:0];
            end else if (wr_w && en_slot_w == go) begin
               out_en_q[go] <= apb_req.pwdata[NI-1:0];
            end
         end
      end
   endgenerate

   // Vector checks cover every input; scalar ones watch input 0
   sequence s_pol_write;
      access_w && apb_req.pwrite && addr_w == event_router_pkg::POL_OFS;
   endsequence

   sequence s_stat0_read;
      setup_w && !apb_req.pwrite && addr_w == event_router_pkg::STAT_BASE;
   endsequence

   sequence s_raw_read;
      setup_w && !apb_req.pwrite && addr_w == event_router_pkg::RAW_OFS;
   endsequence

   sequence s_mode_write;
      access_w && apb_req.pwrite && addr_w == event_router_pkg::MODE_OFS;
   endsequence

   sequence s_gen_write;
      access_w && apb_req.pwrite && addr_w == event_router_pkg::GEN_EN_OFS;
   endsequence

   property p_polarity;
      @(posedge pclk) disable iff (!presetn)
         act_w[0] == (pin_w[0] == pol_q[0]);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("active level does not follow polarity");

   property p_pol_write;
      @(posedge pclk) disable iff (!presetn)
         s_pol_write |=> pol_q == $past(apb_req.pwdata[NI-1:0]);
   endproperty
   a_pol_write: assert property (p_pol_write)
      else $error("polarity write not stored");

   property p_direct_drop;
      @(posedge pclk) disable iff (!presetn)
         !mode_q[0] && !act_w[0] |-> !ev_w[0];
   endproperty
   a_direct_drop: assert property (p_direct_drop)
      else $error("direct event outlives its input");

   property p_edge_latch;
      @(posedge pclk) disable iff (!presetn)
         |edge_w |=> (lat_q & ev_w & $past(edge_w)) == $past(edge_w);
   endproperty
   a_edge_latch: assert property (p_edge_latch)
      else $error("edge not latched");

   property p_latch_hold;
      @(posedge pclk) disable iff (!presetn)
         |(lat_q & ~clr_w) |=> (lat_q & $past(lat_q & ~clr_w)) == $past(lat_q & ~clr_w);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latched event lost without clear");

   property p_global_mask;
      @(posedge pclk) disable iff (!presetn)
         !gen_en_q[0] |-> !route_w[0][0] && !route_w[NO-1][0];
   endproperty
   a_global_mask: assert property (p_global_mask)
      else $error("globally masked input reaches an output");

   property p_irq_route;
      @(posedge pclk) disable iff (!presetn)
         |(ev_w & gen_en_q & out_en_q[1]) |-> irq[1];
   endproperty
   a_irq_route: assert property (p_irq_route)
      else $error("routed event does not raise its output");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
         |(ev_w & gen_en_q & out_en_q[NO-1]) |-> wake;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake not raised by routed event");

   property p_status_read;
      @(posedge pclk) disable iff (!presetn)
         s_stat0_read |=> apb_rsp.prdata == $past(widen(route_w[0]));
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read mismatch");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
         access_w && !mapped_w |-> apb_rsp.pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access without error");

   property p_raw_read;
      @(posedge pclk) disable iff (!presetn)
         s_raw_read |=> apb_rsp.prdata == $past(widen(act_w));
   endproperty
   a_raw_read: assert property (p_raw_read)
      else $error("raw level read mismatch");

   property p_mode_write;
      @(posedge pclk) disable iff (!presetn)
         s_mode_write |=> mode_q == $past(apb_req.pwdata[NI-1:0]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode write not stored");

   property p_gen_write;
      @(posedge pclk) disable iff (!presetn)
         s_gen_write |=> gen_en_q == $past(apb_req.pwdata[NI-1:0]);
   endproperty
   a_gen_write: assert property (p_gen_write)
      else $error("global enable write not stored");

   property p_out_en0_write;
      @(posedge pclk) disable iff (!presetn)
         access_w && apb_req.pwrite && addr_w == event_router_pkg::OUT_EN_BASE
         |=> out_en_q[0] == $past(apb_req.pwdata[NI-1:0]);
   endproperty
   a_out_en0_write: assert property (p_out_en0_write)
      else $error("output enable write not stored");

   property p_latch_clear;
      @(posedge pclk) disable iff (!presetn)
         |(clr_w & ~edge_w) |=> (lat_q & $past(clr_w & ~edge_w)) == '0;
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("cleared latch still set");

   property p_edge_needs_mode;
      @(posedge pclk) disable iff (!presetn)
         |(~mode_q & ~lat_q) |=> (lat_q & $past(~mode_q & ~lat_q)) == '0;
   endproperty
   a_edge_needs_mode: assert property (p_edge_needs_mode)
      else $error("direct input was latched");

   property p_irq0_clear;
      @(posedge pclk) disable iff (!presetn)
         (ev_w & gen_en_q & out_en_q[0]) == '0 |-> !irq[0];
   endproperty
   a_irq0_clear: assert property (p_irq0_clear)
      else $error("interrupt high with no routed event");

   property p_wake_clear;
      @(posedge pclk) disable iff (!presetn)
         (ev_w & gen_en_q & out_en_q[NO-1]) == '0 |-> !wake;
   endproperty
   a_wake_clear: assert property (p_wake_clear)
      else $error("wake high with no routed event");
endmodule : event_router
